//--- hw/sarcs_pkg.sv
// Shared constants for the conversion sequencer and its host.
package sarcs_pkg;
  localparam int unsigned DATA_W = 12;
  localparam int unsigned CNT_W = 20;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned CLK_PERIOD_NS = 100;
  // Start-to-clock setup margin, rounded up to whole cycles.
  localparam int unsigned SETUP_NS = 10;
  localparam int unsigned SETUP_CYCLES = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Conversion lengths in master-clock half periods: 16.5 and 17.5 periods.
  localparam int unsigned CONV_HALVES = 33;
  localparam int unsigned CONV_HALVES_LATE = 35;
  // Power-up timeout plus self-calibration.
  localparam int unsigned CAL_MS = 70;
  localparam int unsigned CAL_CYCLES = CAL_MS * (CLK_HZ / 1000);
  // Least acquisition time between busy falling and the next start.
  localparam int unsigned ACQ_NS = 400;
  localparam int unsigned ACQ_CYCLES = (ACQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Quiet bus time before a start rising edge.
  localparam int unsigned GUARD_NS = 200;
  localparam int unsigned GUARD_CYCLES = (GUARD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Host master clock: toggles every MCLK_HALF system cycles.
  localparam int unsigned MCLK_HALF = 4;
  localparam int unsigned ACQ_HALVES = 3;
  localparam int unsigned RATE_ACQ_CYCLES = ACQ_HALVES * MCLK_HALF;
  localparam int unsigned HOST_ACQ_CYCLES =
      (RATE_ACQ_CYCLES > ACQ_CYCLES) ? RATE_ACQ_CYCLES : ACQ_CYCLES;
  localparam int unsigned START_LOW_CYCLES = GUARD_CYCLES + 2;
  localparam int unsigned WR_LOW_CYCLES = 6;
  localparam int unsigned WR_HOLD_CYCLES = 4;
  // The result reaches the host's filtered copy of the bus eight cycles after the
  // strobe falls, so the strobe stays low two cycles beyond that before the capture.
  localparam int unsigned RD_CYCLES = 10;
  // Control word fields on the data bus.
  localparam int unsigned CTRL_START_BIT = 0;
  localparam int unsigned CTRL_RANGE_BIT = 1;
  // Device input synchroniser vector positions.
  localparam int unsigned DSYNC_W = 7;
  localparam int unsigned DS_MCLK = 6;
  localparam int unsigned DS_START = 5;
  localparam int unsigned DS_CS = 4;
  localparam int unsigned DS_RD = 3;
  localparam int unsigned DS_WR = 2;
  localparam int unsigned DS_RANGE = 1;
  localparam int unsigned DS_SWSTART = 0;
  // Host command codes.
  localparam logic [1:0] OP_PIN_START = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
endpackage

//--- hw/sarcs_if.sv
// Pin-level link between the converter sequencer and its host.
`timescale 1ns/1ps
interface sarcs_if;
  logic master_clock_in;
  logic convert_start_n;
  logic cs_n;
  logic rd_n;
  logic wr_n;
  logic busy;
  logic [sarcs_pkg::DATA_W-1:0] host_data;
  logic host_data_oe;
  logic [sarcs_pkg::DATA_W-1:0] dev_data;
  logic dev_data_oe;
  logic [sarcs_pkg::DATA_W-1:0] data_bus;

  // Shared data wire; an undriven bus reads as zero.
  assign data_bus = dev_data_oe ? dev_data : (host_data_oe ? host_data : '0);

  modport device(
    input master_clock_in, convert_start_n, cs_n, rd_n, wr_n, data_bus,
    output busy, dev_data, dev_data_oe
  );
  modport host(
    input busy, data_bus,
    output master_clock_in, convert_start_n, cs_n, rd_n, wr_n, host_data, host_data_oe
  );
endinterface

//--- hw/sarcs_device.sv
// Converter end: start alignment, conversion timing, calibration and read-out.
`timescale 1ns/1ps
module sarcs_device #(
  parameter int unsigned CAL_CYCLES = sarcs_pkg::CAL_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  sarcs_if.device link,
  input wire logic [sarcs_pkg::DATA_W-1:0] sample_code,
  output logic track_hold,
  output logic calibrating,
  output logic cal_pending,
  output logic sw_start_bit,
  output logic bipolar
);
  typedef enum {SARCS_IDLE, SARCS_WAIT_EDGE, SARCS_CONVERT, SARCS_CALIB} sarcs_state_t;

  localparam logic [sarcs_pkg::CNT_W-1:0] SETUP_C = sarcs_pkg::CNT_W'(sarcs_pkg::SETUP_CYCLES);
  localparam logic [sarcs_pkg::CNT_W-1:0] HALVES = sarcs_pkg::CNT_W'(sarcs_pkg::CONV_HALVES);
  localparam logic [sarcs_pkg::CNT_W-1:0] HALVES_LATE =
      sarcs_pkg::CNT_W'(sarcs_pkg::CONV_HALVES_LATE);
  localparam logic [sarcs_pkg::CNT_W-1:0] CAL_LAST = sarcs_pkg::CNT_W'(CAL_CYCLES - 1);

  // Output coding for the selected input range.
  function automatic logic [sarcs_pkg::DATA_W-1:0] code_fn(
    input logic [sarcs_pkg::DATA_W-1:0] raw,
    input logic bip
  );
    code_fn = bip ? {~raw[sarcs_pkg::DATA_W-1], raw[sarcs_pkg::DATA_W-2:0]} : raw;
  endfunction

  logic [sarcs_pkg::DSYNC_W-1:0] in_vec;
  logic [sarcs_pkg::DSYNC_W-1:0] s1_reg, s2_reg, s3_reg, filt_reg;
  logic [sarcs_pkg::DSYNC_W-1:0] filt_next;
  sarcs_state_t state_reg, state_next;
  logic [sarcs_pkg::CNT_W-1:0] cnt_reg, cnt_next;
  logic [sarcs_pkg::CNT_W-1:0] need_reg, need_next;
  logic [sarcs_pkg::CNT_W-1:0] since_reg, since_next;
  logic busy_reg, busy_next;
  logic hold_reg, hold_next;
  logic sw_reg, sw_next;
  logic cal_reg, cal_next;
  logic calrun_reg, calrun_next;
  logic range_reg, range_next;
  logic [sarcs_pkg::DATA_W-1:0] samp_reg, samp_next;
  logic [sarcs_pkg::DATA_W-1:0] res_reg, res_next;
  logic [sarcs_pkg::DATA_W-1:0] dout_reg, dout_next;
  logic doe_reg, doe_next;
  logic mclk_edge, mclk_fall, pin_rise, wr_end, sw_req;

  // All pins come from the host's timing, so each passes three flops.
  assign in_vec = {link.master_clock_in, link.convert_start_n, link.cs_n, link.rd_n,
                   link.wr_n, link.data_bus[sarcs_pkg::CTRL_RANGE_BIT],
                   link.data_bus[sarcs_pkg::CTRL_START_BIT]};

  // A pin level is accepted once the second and third flops agree.
  always_comb begin
    for (int i = 0; i < sarcs_pkg::DSYNC_W; i++) begin
      filt_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : filt_reg[i];
    end
  end

  // Events seen on the filtered pins.
  assign mclk_edge = filt_next[sarcs_pkg::DS_MCLK] != filt_reg[sarcs_pkg::DS_MCLK];
  assign mclk_fall = mclk_edge & ~filt_next[sarcs_pkg::DS_MCLK];
  assign pin_rise = ~filt_reg[sarcs_pkg::DS_START] & filt_next[sarcs_pkg::DS_START];
  assign wr_end = ~filt_reg[sarcs_pkg::DS_WR] & filt_next[sarcs_pkg::DS_WR]
                  & ~filt_reg[sarcs_pkg::DS_CS];
  // Write data is taken from the value held before the strobe rose.
  assign sw_req = wr_end & filt_reg[sarcs_pkg::DS_SWSTART];

  // Sequencer next-state logic.
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    need_next = need_reg;
    since_next = (since_reg == '1) ? since_reg : since_reg + 1'b1;
    busy_next = busy_reg;
    hold_next = hold_reg;
    sw_next = sw_reg;
    cal_next = cal_reg;
    calrun_next = calrun_reg;
    range_next = range_reg;
    samp_next = samp_reg;
    res_next = res_reg;
    // Read-out follows the filtered strobes, so the bus is released a few cycles late.
    doe_next = ~filt_next[sarcs_pkg::DS_CS] & ~filt_next[sarcs_pkg::DS_RD];
    dout_next = res_reg;
    if (wr_end) begin
      cal_next = 1'b0;
    end
    unique case (state_reg)
      SARCS_IDLE: begin
        if (wr_end) begin
          range_next = filt_reg[sarcs_pkg::DS_RANGE];
        end
        if (pin_rise && cal_reg) begin
          state_next = SARCS_CALIB;
          cal_next = 1'b0;
          calrun_next = 1'b1;
          busy_next = 1'b1;
          cnt_next = '0;
        end else if (pin_rise || sw_req) begin
          state_next = SARCS_WAIT_EDGE;
          hold_next = 1'b1;
          busy_next = 1'b1;
          sw_next = sw_req;
          samp_next = sample_code;
          since_next = '0;
        end
      end
      SARCS_WAIT_EDGE: begin
        if (mclk_fall) begin
          state_next = SARCS_CONVERT;
          cnt_next = '0;
          need_next = (since_reg >= SETUP_C) ? HALVES : HALVES_LATE;
        end
      end
      SARCS_CONVERT: begin
        // Starts that arrive here are dropped; the sequence is not restartable.
        if (mclk_edge) begin
          cnt_next = cnt_reg + 1'b1;
          if (cnt_reg + 1'b1 == need_reg) begin
            state_next = SARCS_IDLE;
            busy_next = 1'b0;
            hold_next = 1'b0;
            sw_next = 1'b0;
            res_next = code_fn(samp_reg, range_reg);
          end
        end
      end
      SARCS_CALIB: begin
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg == CAL_LAST) begin
          state_next = SARCS_IDLE;
          busy_next = 1'b0;
          calrun_next = 1'b0;
        end
      end
    endcase
  end

  // Register stage for synchroniser and sequencer.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_reg <= '1;
      s2_reg <= '1;
      s3_reg <= '1;
      filt_reg <= '1;
      state_reg <= SARCS_IDLE;
      cnt_reg <= '0;
      need_reg <= '0;
      since_reg <= '0;
      busy_reg <= 1'b0;
      hold_reg <= 1'b0;
      sw_reg <= 1'b0;
      cal_reg <= 1'b1;
      calrun_reg <= 1'b0;
      range_reg <= 1'b0;
      samp_reg <= '0;
      res_reg <= '0;
      dout_reg <= '0;
      doe_reg <= 1'b0;
    end else begin
      s1_reg <= in_vec;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      filt_reg <= filt_next;
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      need_reg <= need_next;
      since_reg <= since_next;
      busy_reg <= busy_next;
      hold_reg <= hold_next;
      sw_reg <= sw_next;
      cal_reg <= cal_next;
      calrun_reg <= calrun_next;
      range_reg <= range_next;
      samp_reg <= samp_next;
      res_reg <= res_next;
      dout_reg <= dout_next;
      doe_reg <= doe_next;
    end
  end

  // Every output is a flop.
  assign link.busy = busy_reg;
  assign link.dev_data = dout_reg;
  assign link.dev_data_oe = doe_reg;
  assign track_hold = hold_reg;
  assign calibrating = calrun_reg;
  assign cal_pending = cal_reg;
  assign sw_start_bit = sw_reg;
  assign bipolar = range_reg;
endmodule // sarcs_device

//--- hw/sarcs_host.sv
// Host end: master clock, start pulses, control writes and result reads.
`timescale 1ns/1ps
module sarcs_host #(
  parameter int unsigned CAL_CYCLES = sarcs_pkg::CAL_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  sarcs_if.host link,
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_op,
  input wire logic [sarcs_pkg::DATA_W-1:0] cmd_data,
  output logic cmd_ready,
  output logic [sarcs_pkg::DATA_W-1:0] result,
  output logic result_valid,
  output logic busy_seen
);
  typedef enum {SARCH_IDLE, SARCH_PIN, SARCH_WAIT_HI, SARCH_WAIT_LO, SARCH_ACQ,
                SARCH_WR, SARCH_WR_BUSY, SARCH_WR_HOLD, SARCH_RD} sarch_state_t;
  localparam int unsigned SW = sarcs_pkg::DATA_W + 1;
  localparam logic [sarcs_pkg::CNT_W-1:0] HALF_LAST = sarcs_pkg::CNT_W'(sarcs_pkg::MCLK_HALF - 1);

  // Counter limit test shared by every timed state.
  function automatic logic at_fn(input logic [sarcs_pkg::CNT_W-1:0] c, input int unsigned n);
    at_fn = c >= sarcs_pkg::CNT_W'(n - 1);
  endfunction

  logic [SW-1:0] s1_reg, s2_reg, s3_reg, filt_reg, filt_next;
  sarch_state_t state_reg, state_next;
  logic [sarcs_pkg::CNT_W-1:0] cnt_reg, cnt_next, div_reg, div_next;
  logic mclk_reg, mclk_next;
  logic start_n_reg, start_n_next, cs_n_reg, cs_n_next, rd_n_reg, rd_n_next;
  logic wr_n_reg, wr_n_next, doe_reg, doe_next, first_reg, first_next, calw_reg, calw_next;
  logic ready_reg, ready_next, rv_reg, rv_next;
  logic [sarcs_pkg::DATA_W-1:0] dout_reg, dout_next, res_reg, res_next;
  logic busy_f;

  // Busy and the data bus come from the device pins and pass three flops.
  always_comb begin
    for (int i = 0; i < SW; i++) begin
      filt_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : filt_reg[i];
    end
  end
  assign busy_f = filt_reg[SW-1];

  // Free-running master clock divider.
  always_comb begin
    div_next = (div_reg == HALF_LAST) ? '0 : div_reg + 1'b1;
    mclk_next = (div_reg == HALF_LAST) ? ~mclk_reg : mclk_reg;
  end

  // Host sequencer; one bus operation at a time keeps reads out of conversions.
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg + 1'b1;
    start_n_next = start_n_reg;
    cs_n_next = cs_n_reg;
    rd_n_next = rd_n_reg;
    wr_n_next = wr_n_reg;
    doe_next = doe_reg;
    dout_next = dout_reg;
    first_next = first_reg;
    calw_next = calw_reg;
    ready_next = 1'b0;
    rv_next = 1'b0;
    res_next = res_reg;
    unique case (state_reg)
      SARCH_IDLE: begin
        ready_next = 1'b1;
        cnt_next = '0;
        if (cmd_valid && ready_reg) begin
          ready_next = 1'b0;
          if (cmd_op == sarcs_pkg::OP_WRITE) begin
            state_next = SARCH_WR;
            cs_n_next = 1'b0;
            wr_n_next = 1'b0;
            doe_next = 1'b1;
            dout_next = cmd_data;
            first_next = 1'b0;
          end else if (cmd_op == sarcs_pkg::OP_READ) begin
            state_next = SARCH_RD;
            cs_n_next = 1'b0;
            rd_n_next = 1'b0;
          end else begin
            // Low time covers the quiet window ahead of the rising edge.
            state_next = SARCH_PIN;
            start_n_next = 1'b0;
            calw_next = first_reg;
            first_next = 1'b0;
          end
        end
      end
      SARCH_PIN: begin
        if (at_fn(cnt_reg, sarcs_pkg::START_LOW_CYCLES)) begin
          start_n_next = 1'b1;
          state_next = SARCH_WAIT_HI;
        end
      end
      SARCH_WAIT_HI: begin
        if (busy_f) begin
          state_next = SARCH_WAIT_LO;
        end
      end
      SARCH_WAIT_LO: begin
        cnt_next = '0;
        if (!busy_f) begin
          state_next = SARCH_ACQ;
        end
      end
      SARCH_ACQ: begin
        // After calibration the wait is the full settling time; else acquisition.
        if (calw_reg ? at_fn(cnt_reg, CAL_CYCLES)
                     : at_fn(cnt_reg, sarcs_pkg::HOST_ACQ_CYCLES)) begin
          state_next = SARCH_IDLE;
          calw_next = 1'b0;
        end
      end
      SARCH_WR: begin
        if (at_fn(cnt_reg, sarcs_pkg::WR_LOW_CYCLES)) begin
          state_next = SARCH_WR_BUSY;
        end
      end
      SARCH_WR_BUSY: begin
        cnt_next = '0;
        if (!busy_f) begin
          state_next = SARCH_WR_HOLD;
          wr_n_next = 1'b1;
          cs_n_next = 1'b1;
        end
      end
      SARCH_WR_HOLD: begin
        // Data stays driven past the strobe so the device sees it settled.
        if (at_fn(cnt_reg, sarcs_pkg::WR_HOLD_CYCLES)) begin
          doe_next = 1'b0;
          state_next = dout_reg[sarcs_pkg::CTRL_START_BIT] ? SARCH_WAIT_HI : SARCH_IDLE;
        end
      end
      SARCH_RD: begin
        if (at_fn(cnt_reg, sarcs_pkg::RD_CYCLES)) begin
          rd_n_next = 1'b1;
          cs_n_next = 1'b1;
          res_next = filt_reg[sarcs_pkg::DATA_W-1:0];
          rv_next = 1'b1;
          state_next = SARCH_IDLE;
        end
      end
    endcase
  end

  // Register stage.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      filt_reg <= '0;
      state_reg <= SARCH_IDLE;
      cnt_reg <= '0;
      div_reg <= '0;
      mclk_reg <= 1'b0;
      start_n_reg <= 1'b1;
      cs_n_reg <= 1'b1;
      rd_n_reg <= 1'b1;
      wr_n_reg <= 1'b1;
      doe_reg <= 1'b0;
      dout_reg <= '0;
      first_reg <= 1'b1;
      calw_reg <= 1'b0;
      ready_reg <= 1'b0;
      rv_reg <= 1'b0;
      res_reg <= '0;
    end else begin
      s1_reg <= {link.busy, link.data_bus};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      filt_reg <= filt_next;
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      div_reg <= div_next;
      mclk_reg <= mclk_next;
      start_n_reg <= start_n_next;
      cs_n_reg <= cs_n_next;
      rd_n_reg <= rd_n_next;
      wr_n_reg <= wr_n_next;
      doe_reg <= doe_next;
      dout_reg <= dout_next;
      first_reg <= first_next;
      calw_reg <= calw_next;
      ready_reg <= ready_next;
      rv_reg <= rv_next;
      res_reg <= res_next;
    end
  end

  assign link.master_clock_in = mclk_reg;
  assign link.convert_start_n = start_n_reg;
  assign link.cs_n = cs_n_reg;
  assign link.rd_n = rd_n_reg;
  assign link.wr_n = wr_n_reg;
  assign link.host_data = dout_reg;
  assign link.host_data_oe = doe_reg;
  assign cmd_ready = ready_reg;
  assign result = res_reg;
  assign result_valid = rv_reg;
  assign busy_seen = filt_reg[SW-1];
endmodule // sarcs_host

//--- tb/sarcs_assertions.sv
// Concurrent checks on the pin link between the converter and its host.
`timescale 1ns/1ps
module sarcs_assertions #(
  parameter int unsigned CAL_CYCLES = sarcs_pkg::CAL_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic convert_start_n,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic busy,
  input wire logic dev_data_oe,
  input wire logic [sarcs_pkg::DATA_W-1:0] data_bus
);
  localparam int CAL_LO = CAL_CYCLES - 4;
  localparam int CAL_HI = CAL_CYCLES + 4;
  logic start_q_reg, wr_q_reg, cs_q_reg, busy_q_reg, first_reg, wrote_reg;
  logic first_next, wrote_next, start_rise, wr_rise, busy_fell;
  logic [7:0] since_reg, since_next;
  logic [19:0] len_reg, len_next;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Edge events and counters; a write ends where wr_n rises while cs_n was low the cycle before.
  always_comb begin
    start_rise = convert_start_n && !start_q_reg;
    wr_rise = wr_n && !wr_q_reg && !cs_q_reg;
    busy_fell = busy_q_reg && !busy;
    since_next = (since_reg == 8'hff) ? since_reg : since_reg + 8'h01;
    if (start_rise || wr_rise) begin
      since_next = 8'h00;
    end
    len_next = busy ? len_reg + 20'h00001 : 20'h00000;
    first_next = first_reg || busy_fell;
    wrote_next = wrote_reg || wr_rise;
  end

  // Cleared by reset, so that a second reset rearms the first-busy checks.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      start_q_reg <= 1'b1;
      wr_q_reg <= 1'b1;
      cs_q_reg <= 1'b1;
      busy_q_reg <= 1'b0;
      first_reg <= 1'b0;
      wrote_reg <= 1'b0;
      since_reg <= 8'hff;
      len_reg <= 20'h00000;
    end else begin
      start_q_reg <= convert_start_n;
      wr_q_reg <= wr_n;
      cs_q_reg <= cs_n;
      busy_q_reg <= busy;
      first_reg <= first_next;
      wrote_reg <= wrote_next;
      since_reg <= since_next;
      len_reg <= len_next;
    end
  end

  AST_PIN_START_BUSY: assert property (start_rise && !busy |-> ##[2:7] busy)
    else $error("busy did not follow a pin start");
  AST_SW_START_BUSY: assert property (wr_rise && data_bus[0] && !busy |-> ##[2:7] busy)
    else $error("busy did not follow a software start");
  AST_BUSY_CAUSE: assert property ($rose(busy) |-> since_reg inside {[1:8]})
    else $error("busy rose without a fresh start");
  AST_BUSY_HOLD: assert property ($rose(busy) |-> busy [*8])
    else $error("busy pulse too short");
  // Busy spans the wait for the fall plus 33 edges, or 35 edges when setup is missed.
  AST_CONV_SPAN: assert property (busy_fell && first_reg |-> len_reg inside {[134:141]})
    else $error("conversion length out of range");
  AST_CAL_SPAN: assert property (busy_fell && !first_reg && !wrote_reg |->
    len_reg inside {[CAL_LO:CAL_HI]})
    else $error("calibration length out of range");
  AST_WRITE_CANCELS_CAL: assert property (busy_fell && !first_reg && wrote_reg |->
    len_reg inside {[134:141]})
    else $error("calibration ran after an early write");
  AST_READ_DRIVES: assert property ($fell(rd_n) && !cs_n |-> ##[2:6] dev_data_oe)
    else $error("read strobe did not enable the result");
  AST_OE_RELEASE: assert property ((rd_n && cs_n) [*6] |-> !dev_data_oe)
    else $error("result driven without a read strobe");
  AST_ACQ_GAP: assert property (busy_fell |-> !start_rise [*8])
    else $error("start came too soon after busy fell");

  // Main scenarios: calibration, plain conversion, software start.
  COV_CAL: cover property (busy_fell && !first_reg && !wrote_reg);
  COV_CONV: cover property (busy_fell && first_reg);
  COV_SW: cover property (wr_rise && data_bus[0]);
  // A start that misses the setup margin before the master clock fall.
  COV_LATE: cover property (busy_fell && first_reg && len_reg == 20'h0008d);
endmodule // sarcs_assertions

//--- tb/sarcs_test.sv
// Self-checking bench with both link ends face to face.
`timescale 1ns/1ps
module sarcs_test;
  localparam int unsigned CAL = 200;
  logic clk, rst, cmd_valid, cmd_ready, result_valid, busy_seen, got, cur_bip;
  logic track_hold, calibrating, cal_pending, sw_start_bit, bipolar;
  logic [1:0] cmd_op;
  logic [11:0] cmd_data, result, sample_code, got_code;
  logic [31:0] seed;
  int err_count, compares, i;

  sarcs_if i_sarcs_if();
  sarcs_device #(.CAL_CYCLES(CAL)) i_sarcs_device (.clk(clk), .rst(rst), .link(i_sarcs_if),
    .sample_code(sample_code), .track_hold(track_hold), .calibrating(calibrating),
    .cal_pending(cal_pending), .sw_start_bit(sw_start_bit), .bipolar(bipolar));
  sarcs_host #(.CAL_CYCLES(CAL)) i_sarcs_host (.clk(clk), .rst(rst), .link(i_sarcs_if),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
    .result(result), .result_valid(result_valid), .busy_seen(busy_seen));
  sarcs_assertions #(.CAL_CYCLES(CAL)) chk (.clk(clk), .rst(rst),
    .convert_start_n(i_sarcs_if.convert_start_n), .cs_n(i_sarcs_if.cs_n),
    .rd_n(i_sarcs_if.rd_n), .wr_n(i_sarcs_if.wr_n), .busy(i_sarcs_if.busy),
    .dev_data_oe(i_sarcs_if.dev_data_oe), .data_bus(i_sarcs_if.data_bus));

  // Free-running 10 MHz clock.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // The read result is a one-cycle pulse, so catch it here.
  always @(posedge clk) begin
    if (result_valid === 1'b1) begin
      got <= 1'b1;
      got_code <= result;
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  // Offset-binary raw code seen through the selected range.
  function automatic logic [11:0] exp_code(input logic [11:0] raw, input logic bip);
    return bip ? {~raw[11], raw[10:0]} : raw;
  endfunction

  task automatic fail(input string what);
    err_count++;
    $display("unexpected at %0t: %s", $time, what);
  endtask

  task automatic check_bit(input logic g, input logic e, input string what);
    compares++;
    if (g !== e) fail(what);
  endtask

  task automatic check_code(input logic [11:0] g, input logic [11:0] e);
    compares++;
    if (g !== e) fail("result code");
  endtask

  task automatic summarize();
    $display("compares %0d errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Bounded waits; the host only reports ready once a whole operation is over.
  task automatic wait_ready();
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 3000) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 3000) fail("ready timeout");
  endtask

  task automatic wait_busy();
    int n;
    n = 0;
    while (i_sarcs_if.busy !== 1'b1 && n < 60) begin
      @(posedge clk);
      #1;
      n++;
    end
    @(posedge clk);
    #1;
  endtask

  task automatic send(input logic [1:0] op, input logic [11:0] d);
    wait_ready();
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_data = d;
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
    @(posedge clk);
    #1;
  endtask

  // One conversion by pin or by register, then a read of its result.
  task automatic convert(input logic sw, input logic bip, input logic [11:0] raw);
    if (sw) cur_bip = bip;
    sample_code = raw;
    send(sw ? sarcs_pkg::OP_WRITE : sarcs_pkg::OP_PIN_START, {seed[23:14], cur_bip, 1'b1});
    wait_busy();
    check_bit(track_hold, 1'b1, "hold at start");
    check_bit(calibrating, 1'b0, "calibrating");
    check_bit(sw_start_bit, sw, "start bit source");
    wait_ready();
    check_bit(busy_seen, 1'b0, "busy seen after end");
    check_bit(track_hold, 1'b0, "track after busy");
    check_bit(sw_start_bit, 1'b0, "start bit left set");
    check_bit(bipolar, cur_bip, "range");
    got = 1'b0;
    send(sarcs_pkg::OP_READ, 12'h000);
    wait_ready();
    @(posedge clk);
    #1;
    check_bit(got, 1'b1, "no read result");
    check_code(got_code, exp_code(raw, cur_bip));
  endtask

  initial begin
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = 2'h0;
    cmd_data = 12'h000;
    sample_code = 12'h000;
    got = 1'b0;
    cur_bip = 1'b0;
    seed = 32'h52a9;
    err_count = 0;
    compares = 0;
    repeat (20) @(posedge clk);
    #1 rst = 1'b0;
    check_bit(cal_pending, 1'b1, "cal not armed");
    send(sarcs_pkg::OP_PIN_START, 12'h000);
    wait_busy();
    check_bit(calibrating, 1'b1, "no calibration");
    check_bit(track_hold, 1'b0, "hold during calibration");
    wait_ready();
    $display("test calibration done");
    // Range ends and the sign boundary first, then random codes.
    for (i = 0; i < 14; i++) begin
      seed = xs(seed);
      case (i)
        0: convert(1'b1, 1'b0, 12'h000);
        1: convert(1'b0, 1'b0, 12'hfff);
        2: convert(1'b1, 1'b1, 12'h800);
        3: convert(1'b0, 1'b1, 12'h7ff);
        default: convert(seed[12], seed[13], seed[11:0]);
      endcase
    end
    $display("test conversions done");
    @(posedge clk);
    #1 rst = 1'b1;
    repeat (3) @(posedge clk);
    #1 rst = 1'b0;
    check_bit(cal_pending, 1'b1, "cal not rearmed");
    send(sarcs_pkg::OP_WRITE, 12'h000);
    wait_ready();
    check_bit(cal_pending, 1'b0, "write kept calibration");
    cur_bip = 1'b0;
    convert(1'b0, 1'b0, 12'h5a5);
    $display("test early write done");
    summarize();
  end

  // Cut a hang short well beyond the expected run of some 3100 cycles.
  initial begin
    repeat (60000) @(posedge clk);
    fail("watchdog expired");
    summarize();
  end
endmodule // sarcs_test
